// ---- dv/tad_detector_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tad_detector_test;
  localparam int W = tad_pkg::SAMPLE_W;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic i_clk_en = 1'b1;
  logic i_sample_valid = 1'b0;
  logic [W-1:0] i_accel_x = '0;
  logic [W-1:0] i_accel_y = '0;
  logic [W-1:0] i_accel_z = '0;
  logic [1:0] i_full_scale_select = 2'h2;
  logic i_low_noise = 1'b0;
  logic i_hybrid_mode = 1'b0;
  logic i_axis_ths_en = 1'b0;
  logic [tad_pkg::AXIS_THS_W-1:0] i_axis_ths_x = 13'h000a;
  logic [tad_pkg::AXIS_THS_W-1:0] i_axis_ths_y = 13'h1fff;
  logic [tad_pkg::AXIS_THS_W-1:0] i_axis_ths_z = 13'h1fff;
  logic [7:0] i_reg_addr = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [7:0] o_reg_rdata;
  logic o_event;
  logic [7:0] v;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;

  tad_detector tad_detector_i (.i_clk_sys, .i_resetn, .i_clk_en, .i_sample_valid,
    .i_accel_x, .i_accel_y, .i_accel_z, .i_full_scale_select, .i_low_noise,
    .i_hybrid_mode, .i_axis_ths_en, .i_axis_ths_x, .i_axis_ths_y, .i_axis_ths_z,
    .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .o_event);

  always #50 i_clk_sys = ~i_clk_sys;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    @(negedge i_clk_sys);
    v = o_reg_rdata;
  endtask : reg_rd

  task automatic samp(input int x, input int y, input int z);
    @(posedge i_clk_sys);
    i_sample_valid <= 1'b1;
    i_accel_x <= W'(x);
    i_accel_y <= W'(y);
    i_accel_z <= W'(z);
    @(posedge i_clk_sys);
    i_sample_valid <= 1'b0;
    @(negedge i_clk_sys);
  endtask : samp

  // lsb first: 1 is a sample of +100 on x, 0 a quiet one
  task automatic pulses(input logic [7:0] pat, input int n);
    for (int i = 0; i < n; i++) begin
      samp(pat[i] ? 100 : 0, 0, 0);
    end
  endtask : pulses

  // m = {hybrid, axis thresholds, low noise, full scale}
  task automatic setup(input logic [7:0] c, input logic [7:0] t, input logic [7:0] n,
                       input logic [4:0] m);
    @(posedge i_clk_sys);
    i_resetn <= 1'b0;
    {i_hybrid_mode, i_axis_ths_en, i_low_noise, i_full_scale_select} <= m;
    repeat (20) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    reg_wr(tad_pkg::ADDR_CONFIG, c);
    reg_wr(tad_pkg::ADDR_THRESHOLD, t);
    reg_wr(tad_pkg::ADDR_COUNT, n);
  endtask : setup

  task automatic t_regs();
    setup(8'hff, 8'hc3, 8'ha5, 5'h02);
    reg_wr(tad_pkg::ADDR_SOURCE, 8'hff);
    reg_rd(tad_pkg::ADDR_CONFIG);
    `CHK("config", 8'h1f, v)
    reg_rd(tad_pkg::ADDR_COUNT);
    `CHK("count", 8'ha5, v)
    reg_rd(tad_pkg::ADDR_THRESHOLD);
    `CHK("threshold", 8'hc3, v)
    reg_rd(tad_pkg::ADDR_SOURCE);
    `CHK("source idle", 8'h00, v)
    reg_rd(8'h30);
    `CHK("unmapped", 8'h00, v)
  endtask : t_regs

  task automatic t_latch();
    setup(8'h1b, 8'h81, 8'h02, 5'h02);
    samp(100, -100, -100);
    `CHK("event early", 1'b0, o_event)
    samp(100, -100, -100);
    `CHK("event", 1'b1, o_event)
    samp(-100, 0, 100);
    samp(-100, 0, 100);
    samp(0, 0, 0);
    `CHK("event held", 1'b1, o_event)
    reg_rd(tad_pkg::ADDR_SOURCE);
    `CHK("source frozen", 8'h72, v)
    reg_rd(tad_pkg::ADDR_SOURCE);
    `CHK("source cleared", 8'h00, v)
    `CHK("event cleared", 1'b0, o_event)
  endtask : t_latch

  task automatic t_debounce();
    setup(8'h03, 8'h01, 8'h03, 5'h02);
    pulses(8'h1b, 5);
    `CHK("decrement mode", 1'b1, o_event)
    pulses(8'h00, 1);
    `CHK("live event", 1'b0, o_event)
    reg_rd(tad_pkg::ADDR_SOURCE);
    `CHK("sticky flag", 8'h42, v)
    setup(8'h03, 8'h81, 8'h03, 5'h02);
    pulses(8'h1b, 5);
    `CHK("clear mode", 1'b0, o_event)
    pulses(8'h01, 1);
    `CHK("clear mode late", 1'b1, o_event)
  endtask : t_debounce

  // full scale code 3 runs as 8 g
  task automatic t_scale();
    int s;
    for (int f = 0; f < 4; f++) begin
      s = (f == 3) ? 64 : (1 << (8 - f));
      setup(8'h03, 8'h81, 8'h00, 5'(f));
      samp(s, 0, 0);
      `CHK("at threshold", 1'b0, o_event)
      samp(s + 1, 0, 0);
      `CHK("above threshold", 1'b1, o_event)
      samp(-s - 1, 0, 0);
      `CHK("negative magnitude", 1'b1, o_event)
    end
  endtask : t_scale

  task automatic t_modes();
    setup(8'h03, 8'hff, 8'h00, 5'h06);
    samp(8191, 0, 0);
    `CHK("low noise cap", 1'b0, o_event)
    setup(8'h03, 8'hff, 8'h00, 5'h07);
    samp(8191, 0, 0);
    `CHK("low noise cap code 3", 1'b0, o_event)
    setup(8'h03, 8'hff, 8'h00, 5'h02);
    samp(8191, 0, 0);
    `CHK("no cap", 1'b1, o_event)
    setup(8'h03, 8'hff, 8'h00, 5'h0a);
    samp(11, 0, 0);
    `CHK("axis threshold", 1'b1, o_event)
    samp(10, 0, 0);
    `CHK("axis threshold edge", 1'b0, o_event)
    setup(8'h03, 8'h81, 8'h02, 5'h12);
    pulses(8'h03, 2);
    `CHK("hybrid half", 1'b0, o_event)
    pulses(8'h03, 2);
    `CHK("hybrid full", 1'b1, o_event)
  endtask : t_modes

  task automatic t_filter();
    setup(8'h02, 8'h81, 8'h00, 5'h02);
    pulses(8'h03, 2);
    `CHK("filtered step", 1'b1, o_event)
    repeat (40) samp(100, 0, 0);
    `CHK("filtered offset", 1'b0, o_event)
    setup(8'h03, 8'h81, 8'h00, 5'h02);
    repeat (40) samp(100, 0, 0);
    `CHK("raw offset", 1'b1, o_event)
  endtask : t_filter

  // clock enable low: neither a sample nor a write may act
  task automatic t_enable();
    setup(8'h03, 8'h81, 8'h00, 5'h02);
    i_clk_en <= 1'b0;
    samp(100, 0, 0);
    reg_wr(tad_pkg::ADDR_CONFIG, 8'h00);
    `CHK("frozen event", 1'b0, o_event)
    i_clk_en <= 1'b1;
    samp(100, 0, 0);
    `CHK("enabled event", 1'b1, o_event)
  endtask : t_enable

  initial begin
    t_regs();
    t_latch();
    t_debounce();
    t_scale();
    t_modes();
    t_filter();
    t_enable();
    finish_test();
  end
endmodule : tad_detector_test
`default_nettype wire

// ---- src/tad_axis_cmp.sv ----
`timescale 1ns/1ps
`default_nettype none
module tad_axis_cmp #(
  parameter int W = tad_pkg::SAMPLE_W
) (
  input wire logic signed [W-1:0] i_sample,
  input wire tad_pkg::tad_fs_e i_full_scale_select,
  input wire logic i_low_noise,
  input wire logic [tad_pkg::THS_W-1:0] i_event_threshold,
  input wire logic i_axis_ths_en,
  input wire logic [tad_pkg::AXIS_THS_W-1:0] i_axis_ths,
  output logic o_beyond,
  output logic o_negative
);
  logic [W:0] sx;
  logic [W:0] mag;
  logic [W:0] ths_eff;

  always_comb begin
    sx = {i_sample[W-1], i_sample};
    o_negative = i_sample[W-1];
    mag = o_negative ? (~sx + 1'b1) : sx;
    // low noise caps the range at 4 g
    // the spare code 3 runs as 8 g, so it is capped as well
    if (i_low_noise && i_full_scale_select != tad_pkg::TAD_FS_2G
        && i_full_scale_select != tad_pkg::TAD_FS_4G
        && mag > tad_pkg::LOW_NOISE_LIMIT_8G) begin
      mag = tad_pkg::LOW_NOISE_LIMIT_8G;
    end
    // threshold step is fixed, so rescale it into sample counts
    unique case (i_full_scale_select)
      tad_pkg::TAD_FS_2G: ths_eff = {i_event_threshold, 8'h00};
      tad_pkg::TAD_FS_4G: ths_eff = {1'b0, i_event_threshold, 7'h00};
      default: ths_eff = {2'b00, i_event_threshold, 6'h00};
    endcase
    if (i_axis_ths_en) begin
      ths_eff = {2'b00, i_axis_ths};
    end
    o_beyond = mag > ths_eff;
  end
endmodule : tad_axis_cmp
`default_nettype wire

// ---- src/tad_detector.sv ----
// Summary of operation
// - bypass bit selects filtered or raw samples
// - bypassed filter compares raw acceleration with offset
// - event when enabled axis beyond threshold long enough
// - disabled axes never contribute to the event
// - latch mode holds event until source read
// - non-latched event output follows live detection
// - latch mode freezes axis flags and polarity
// - live mode updates flags; read alone clears
// - summary bit is or of axis flags
// - axis flag only after full debounce count
// - polarity zero positive, one negative
// - mode zero decrements counter when condition false
// - mode one clears counter when condition false
// - seven-bit threshold at fixed eight-g scale
// - low noise limits range to four g
// - per-axis thresholds replace common threshold
// - debounce count register at 0x20
// - hybrid mode steps counter every other sample
`timescale 1ns/1ps
`default_nettype none
module tad_detector #(
  parameter int W = tad_pkg::SAMPLE_W,
  parameter int CNT_W = tad_pkg::COUNT_W
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_clk_en,
  input wire logic i_sample_valid,
  input wire logic [W-1:0] i_accel_x,
  input wire logic [W-1:0] i_accel_y,
  input wire logic [W-1:0] i_accel_z,
  input wire logic [1:0] i_full_scale_select,
  input wire logic i_low_noise,
  input wire logic i_hybrid_mode,
  input wire logic i_axis_ths_en,
  input wire logic [tad_pkg::AXIS_THS_W-1:0] i_axis_ths_x,
  input wire logic [tad_pkg::AXIS_THS_W-1:0] i_axis_ths_y,
  input wire logic [tad_pkg::AXIS_THS_W-1:0] i_axis_ths_z,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_event
);
  localparam int AXES = tad_pkg::AXES;

  logic rst_meta;
  logic rst_n;
  logic [7:0] transient_config;
  logic [7:0] transient_threshold;
  logic [CNT_W-1:0] debounce_count;
  logic [7:0] next_config;
  logic [7:0] next_threshold;
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic phase;
  logic next_phase;
  logic live_active;
  logic next_live;
  logic [AXES-1:0] axis_flag;
  logic [AXES-1:0] axis_pol;
  logic [AXES-1:0] next_flag;
  logic [AXES-1:0] next_pol;
  logic next_event;
  logic [7:0] next_rdata;
  logic [7:0] source_value;
  logic step;
  logic cond;
  logic trig;
  logic trig_step;
  logic read_src;
  logic any_event_active;
  logic allowed;
  logic [AXES-1:0] beyond;
  logic [AXES-1:0] negative;
  logic [AXES-1:0] hit;
  logic [AXES-1:0][W-1:0] raw;
  logic [AXES-1:0][W-1:0] filt;
  logic [AXES-1:0][W-1:0] det;
  logic [AXES-1:0][tad_pkg::AXIS_THS_W-1:0] axis_ths;

  assign raw = {i_accel_z, i_accel_y, i_accel_x};
  assign axis_ths = {i_axis_ths_z, i_axis_ths_y, i_axis_ths_x};

  // reset release through two flops; clock enable does not hold it
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  for (genvar i = 0; i < AXES; i++) begin : g_axis
    tad_hpf #(
      .W(W),
      .K(tad_pkg::HPF_SHIFT)
    ) u_hpf (
      .i_clk(i_clk_sys),
      .i_rst_n(rst_n),
      .i_clk_en(i_clk_en),
      .i_valid(i_sample_valid),
      .i_sample(raw[i]),
      .o_sample(filt[i])
    );
    assign det[i] = transient_config[tad_pkg::CFG_BYPASS] ? raw[i] : filt[i];
    tad_axis_cmp #(
      .W(W)
    ) u_cmp (
      .i_sample(det[i]),
      .i_full_scale_select(tad_pkg::tad_fs_e'(i_full_scale_select)),
      .i_low_noise(i_low_noise),
      .i_event_threshold(transient_threshold[tad_pkg::THS_W-1:0]),
      .i_axis_ths_en(i_axis_ths_en),
      .i_axis_ths(axis_ths[i]),
      .o_beyond(beyond[i]),
      .o_negative(negative[i])
    );
    assign hit[i] = beyond[i] && transient_config[tad_pkg::CFG_AXIS_EN + i];
    assign source_value[2*i] = axis_pol[i];
    assign source_value[2*i+1] = axis_flag[i];
  end

  assign any_event_active = |axis_flag;
  assign source_value[tad_pkg::SRC_ANY_EVENT] = any_event_active;
  assign source_value[7] = 1'b0;
  assign read_src = i_reg_rd && i_reg_addr == tad_pkg::ADDR_SOURCE;

  // register writes and read data
  always_comb begin
    next_config = transient_config;
    next_threshold = transient_threshold;
    next_count = debounce_count;
    next_rdata = o_reg_rdata;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        tad_pkg::ADDR_CONFIG: next_config = i_reg_wdata & tad_pkg::CFG_WRITE_MASK;
        tad_pkg::ADDR_THRESHOLD: next_threshold = i_reg_wdata;
        tad_pkg::ADDR_COUNT: next_count = i_reg_wdata[CNT_W-1:0];
        default: next_count = debounce_count;
      endcase
    end
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        tad_pkg::ADDR_CONFIG: next_rdata = transient_config;
        tad_pkg::ADDR_SOURCE: next_rdata = source_value;
        tad_pkg::ADDR_THRESHOLD: next_rdata = transient_threshold;
        tad_pkg::ADDR_COUNT: next_rdata = 8'(debounce_count);
        default: next_rdata = tad_pkg::RDATA_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      transient_config <= tad_pkg::RST_CONFIG;
      transient_threshold <= tad_pkg::RST_THRESHOLD;
      debounce_count <= CNT_W'(tad_pkg::RST_COUNT);
      o_reg_rdata <= tad_pkg::RDATA_UNMAPPED;
    end else if (i_clk_en) begin
      transient_config <= next_config;
      transient_threshold <= next_threshold;
      debounce_count <= next_count;
      o_reg_rdata <= next_rdata;
    end
  end

  // debounce counter, one step per output sample period
  assign step = i_clk_en && i_sample_valid && (!i_hybrid_mode || phase);
  assign cond = |hit;

  always_comb begin
    next_phase = phase;
    next_cnt = cnt;
    next_live = live_active;
    trig = 1'b0;
    if (i_sample_valid) begin
      next_phase = i_hybrid_mode ? !phase : 1'b0;
    end
    if (step) begin
      if (cond) begin
        next_cnt = (cnt < debounce_count) ? cnt + 1'b1 : debounce_count;
        trig = next_cnt == debounce_count;
      end else if (transient_threshold[tad_pkg::THS_DEBOUNCE_MODE]) begin
        next_cnt = '0;
      end else if (cnt != '0) begin
        next_cnt = cnt - 1'b1;
      end
      next_live = trig;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 1'b0;
      cnt <= '0;
      live_active <= 1'b0;
    end else if (i_clk_en) begin
      phase <= next_phase;
      cnt <= next_cnt;
      live_active <= next_live;
    end
  end

  // source flags; a trigger in the reading cycle survives the clear
  assign trig_step = step && trig;
  assign allowed = trig_step
    && !(transient_config[tad_pkg::CFG_LATCH] && any_event_active && !read_src);

  always_comb begin
    next_flag = read_src ? '0 : axis_flag;
    next_pol = read_src ? '0 : axis_pol;
    if (allowed) begin
      next_flag = next_flag | hit;
      next_pol = (next_pol & ~hit) | (negative & hit);
    end
    next_event = transient_config[tad_pkg::CFG_LATCH] ? |next_flag : next_live;
  end

  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      axis_flag <= '0;
      axis_pol <= '0;
      o_event <= 1'b0;
    end else if (i_clk_en) begin
      axis_flag <= next_flag;
      axis_pol <= next_pol;
      o_event <= next_event;
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!rst_n);

  a_bypass_select: assert property (
    det[0] == (transient_config[tad_pkg::CFG_BYPASS] ? raw[0] : filt[0]))
    else $error("detector input does not follow bypass bit");

  a_flag_after_count: assert property (
    (!axis_flag[0] ##1 axis_flag[0]) |-> $past(trig_step))
    else $error("axis flag set without debounce trigger");

  a_summary_bit: assert property (
    source_value[tad_pkg::SRC_ANY_EVENT] == (axis_flag != '0))
    else $error("summary bit differs from axis flags");

  a_latch_freeze: assert property (
    (transient_config[tad_pkg::CFG_LATCH] && any_event_active && !read_src)
    |=> ($stable(axis_flag) && $stable(axis_pol)))
    else $error("latched source bits changed");

  a_read_clears: assert property (
    (i_clk_en && read_src && !trig_step) |=> (axis_flag == '0 && axis_pol == '0))
    else $error("source read did not clear flags");

  a_flags_sticky: assert property (
    (i_clk_en && axis_flag[1] && !read_src) |=> axis_flag[1])
    else $error("axis flag dropped without a read");

  a_live_event: assert property (
    (i_clk_en && !transient_config[tad_pkg::CFG_LATCH]) |=> (o_event == live_active))
    else $error("live event output wrong");

  a_latched_event: assert property (
    (i_clk_en && transient_config[tad_pkg::CFG_LATCH] && any_event_active && !read_src)
    |=> o_event)
    else $error("latched event dropped before read");

  a_decrement_mode: assert property (
    (step && !cond && !transient_threshold[tad_pkg::THS_DEBOUNCE_MODE] && cnt != '0)
    |=> cnt == $past(cnt) - 1'b1)
    else $error("debounce counter not decremented");

  a_clear_mode: assert property (
    (step && !cond && transient_threshold[tad_pkg::THS_DEBOUNCE_MODE]) |=> cnt == '0)
    else $error("debounce counter not cleared");

  a_count_advance: assert property (
    (step && cond && cnt < debounce_count) |=> cnt == $past(cnt) + 1'b1)
    else $error("debounce counter not advanced");

  a_axis_ignored: assert property (
    (step && hit == '0 && beyond != '0 && transient_threshold[tad_pkg::THS_DEBOUNCE_MODE])
    |=> cnt == '0)
    else $error("disabled axis moved the counter");

  a_hybrid_half: assert property (
    (i_clk_en && i_sample_valid && i_hybrid_mode && !phase) |-> !step)
    else $error("hybrid mode stepped on skipped sample");

  a_polarity_capture: assert property (
    (i_clk_en && allowed && hit[2]) |=> axis_pol[2] == $past(negative[2]))
    else $error("polarity not captured");
endmodule : tad_detector
`default_nettype wire

// ---- src/tad_hpf.sv ----
`timescale 1ns/1ps
`default_nettype none
module tad_hpf #(
  parameter int W = tad_pkg::SAMPLE_W,
  parameter int K = tad_pkg::HPF_SHIFT
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_valid,
  input wire logic signed [W-1:0] i_sample,
  output logic signed [W-1:0] o_sample
);
  logic signed [W-1:0] x_prev;
  logic signed [W-1:0] next_x_prev;
  logic signed [W-1:0] next_y;
  logic signed [W+1:0] acc;
  logic signed [W+1:0] ye;
  logic signed [W+1:0] xe;
  logic signed [W+1:0] pe;

  // first order high pass: y += dx - y/2^K, saturated to the sample width
  always_comb begin
    ye = {{2{o_sample[W-1]}}, o_sample};
    xe = {{2{i_sample[W-1]}}, i_sample};
    pe = {{2{x_prev[W-1]}}, x_prev};
    acc = ye + xe - pe - (ye >>> K);
    next_y = o_sample;
    next_x_prev = x_prev;
    if (i_valid) begin
      next_x_prev = i_sample;
      if (acc[W+1:W-1] == '0 || acc[W+1:W-1] == '1) begin
        next_y = acc[W-1:0];
      end else begin
        next_y = acc[W+1] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sample <= '0;
      x_prev <= '0;
    end else if (i_clk_en) begin
      o_sample <= next_y;
      x_prev <= next_x_prev;
    end
  end
endmodule : tad_hpf
`default_nettype wire

// ---- src/tad_pkg.sv ----
`default_nettype none
package tad_pkg;
  // register offsets
  localparam logic [7:0] ADDR_CONFIG = 8'h1d;
  localparam logic [7:0] ADDR_SOURCE = 8'h1e;
  localparam logic [7:0] ADDR_THRESHOLD = 8'h1f;
  localparam logic [7:0] ADDR_COUNT = 8'h20;
  // reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
  // transient_config fields: axis enable of axis i sits at CFG_AXIS_EN + i
  localparam int CFG_BYPASS = 0;
  localparam int CFG_AXIS_EN = 1;
  localparam int CFG_LATCH = 4;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h1f;
  // transient_source fields: polarity at 2*i, event flag at 2*i+1
  localparam int SRC_ANY_EVENT = 6;
  // transient_threshold fields
  localparam int THS_DEBOUNCE_MODE = 7;
  localparam int THS_W = 7;
  // data widths
  localparam int AXES = 3;
  localparam int SAMPLE_W = 14;
  localparam int AXIS_THS_W = 13;
  localparam int COUNT_W = 8;
  localparam int HPF_SHIFT = 4;
  // 4 g in counts at the 8 g setting (1024 counts per g)
  localparam logic [SAMPLE_W:0] LOW_NOISE_LIMIT_8G = 15'h1000;
  typedef enum logic [1:0] {
    TAD_FS_2G = 2'h0,
    TAD_FS_4G = 2'h1,
    TAD_FS_8G = 2'h2
  } tad_fs_e;
endpackage : tad_pkg
`default_nettype wire
